// file: mswc_pkg.sv
// Shared constants and types for the block-mode sector write command logic.
package mswc_pkg;

  // ----------------------------------------------------------------------
  // Task-file register addresses
  // ----------------------------------------------------------------------
  localparam logic [2:0] TF_DATA = 3'h0;
  localparam logic [2:0] TF_FEAT_ERR = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_SECT = 3'h3;
  localparam logic [2:0] TF_CYL_LO = 3'h4;
  localparam logic [2:0] TF_CYL_HI = 3'h5;
  localparam logic [2:0] TF_DEV_HEAD = 3'h6;
  localparam logic [2:0] TF_CMD_STAT = 3'h7;

  // ----------------------------------------------------------------------
  // Command codes and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WR_MULTI = 8'hC5;
  localparam logic [7:0] OP_WR_MULTI_EXT = 8'h39;
  localparam int DH_LBA_BIT = 6;
  localparam int ERR_IDN_BIT = 4;
  localparam int ERR_ABT_BIT = 2;
  localparam int ST_BSY_BIT = 7;
  localparam int ST_DF_BIT = 5;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;

  // ----------------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] WORD_LAST = 8'hFF;
  localparam logic [16:0] COUNT28_ZERO = 17'h00100;
  localparam logic [16:0] COUNT48_ZERO = 17'h10000;
  localparam logic [7:0] CHS_SECT_FIRST = 8'h01;
  localparam logic [7:0] CHS_SECT_LAST = 8'h3F;
  localparam logic [3:0] CHS_HEAD_LAST = 4'hF;
  localparam logic [7:0] TF_RESET_BYTE = 8'h00;
  localparam logic [7:0] TF_RESET_ONE = 8'h01;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } mswc_host_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_COMMIT = 2'b11,
    ST_END = 2'b10
  } mswc_state_t;

endpackage

// file: mswc_fifo.sv
// Word FIFO with a registered output stage between host data and media.
`timescale 1ns/100ps
module mswc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_flush,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic push;
  logic pop;

  assign push = i_ce & i_valid & o_ready;
  assign pop = i_ce & (count_r != '0) & (~o_valid | i_ready);
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= i_data;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      o_ready <= 1'b1;
    end
    else if (i_ce)
    begin
      if (i_flush)
      begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
        count_r <= '0;
        o_ready <= 1'b1;
      end
      else
      begin
        if (push)
          wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
        if (pop)
          rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
        count_r <= count_nxt;
        // Full is registered so the ready seen by the host is a clean flop.
        o_ready <= (count_nxt != (AW+1)'(DEPTH));
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
    end
    else if (i_ce)
    begin
      if (i_flush)
        o_valid <= 1'b0;
      else if (pop)
      begin
        o_valid <= 1'b1;
        o_data <= mem[rd_ptr_r];
      end
      else if (i_ready)
        o_valid <= 1'b0;
    end
  end
endmodule

// file: mswc_write_multi.sv
// Device-side task-file logic for the block-mode sector write commands.
`timescale 1ns/100ps
module mswc_write_multi (
  // Clock, reset and enable
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_CE,
  // Task-file access from the host interface
  input wire mswc_pkg::mswc_host_req_t I_HOST_REQ,
  input wire logic I_HOB,
  input wire logic [7:0] I_BLOCK_SIZE,
  output logic [15:0] O_RDATA,
  output logic O_DATA_READY,
  output logic O_INTRQ,
  // Media write stream
  output logic O_MEDIA_VALID,
  output logic [15:0] O_MEDIA_DATA,
  input wire logic I_MEDIA_READY,
  input wire logic I_MEDIA_FAIL
);
  import mswc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mswc_state_t state_r;
  logic [7:0] tf_cur_r [2:5];
  logic [7:0] tf_prev_r [2:5];
  logic [7:0] dh_r;
  logic [7:0] err_r;
  logic err_flag_r;
  logic ext_r;
  logic lba_r;
  logic drq_r;
  logic [16:0] rem_r;
  logic [16:0] rem_in_r;
  logic [7:0] blk_left_r;
  logic [7:0] in_word_r;
  logic [7:0] out_word_r;
  logic [47:0] cur_r;
  logic [47:0] last_r;

  logic host_wr;
  logic host_rd;
  logic cmd_wr;
  logic cmd_ok;
  logic is_ext;
  logic fifo_ready;
  logic data_acc;
  logic sector_in;
  logic sector_commit;
  logic fail;
  logic [16:0] count_req;
  logic [47:0] start_addr;
  logic [47:0] end_addr;
  logic [7:0] status;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] blk_len(input logic [16:0] rem,
                                         input logic [7:0] bs);
    blk_len = (rem > {9'h000, bs}) ? bs : rem[7:0];
  endfunction

  // Sector-number field is 1-based within a track in CHS form.
  function automatic logic [47:0] next_addr(input logic [47:0] a,
                                            input logic lin);
    logic [47:0] n;
    n = a;
    if (lin)
      n = a + 48'h1;
    else if (a[7:0] != CHS_SECT_LAST)
      n[7:0] = a[7:0] + 8'h01;
    else
    begin
      n[7:0] = CHS_SECT_FIRST;
      if (a[27:24] != CHS_HEAD_LAST)
        n[27:24] = a[27:24] + 4'h1;
      else
      begin
        n[27:24] = 4'h0;
        n[23:8] = a[23:8] + 16'h0001;
      end
    end
    next_addr = n;
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign host_wr = I_CE & I_HOST_REQ.wr;
  assign host_rd = I_CE & I_HOST_REQ.rd;
  assign cmd_wr = host_wr & (I_HOST_REQ.addr == TF_CMD_STAT)
    & (state_r == ST_IDLE);
  assign is_ext = (I_HOST_REQ.wdata[7:0] == OP_WR_MULTI_EXT);
  // A zero block size means block mode is not configured.
  assign cmd_ok = (is_ext | (I_HOST_REQ.wdata[7:0] == OP_WR_MULTI))
    & (I_BLOCK_SIZE != 8'h00);
  assign data_acc = host_wr & (I_HOST_REQ.addr == TF_DATA)
    & (state_r == ST_XFER) & drq_r & fifo_ready;
  assign sector_in = data_acc & (in_word_r == WORD_LAST);
  assign sector_commit = I_CE & O_MEDIA_VALID & I_MEDIA_READY
    & (out_word_r == WORD_LAST);
  assign fail = I_CE & I_MEDIA_FAIL
    & ((state_r == ST_XFER) | (state_r == ST_COMMIT));

  always_comb
  begin
    if (is_ext)
    begin
      count_req = ({tf_prev_r[2], tf_cur_r[2]} == 16'h0000) ? COUNT48_ZERO
        : {1'b0, tf_prev_r[2], tf_cur_r[2]};
      start_addr = {tf_prev_r[5], tf_prev_r[4], tf_prev_r[3],
                    tf_cur_r[5], tf_cur_r[4], tf_cur_r[3]};
    end
    else
    begin
      count_req = (tf_cur_r[2] == 8'h00) ? COUNT28_ZERO
        : {9'h000, tf_cur_r[2]};
      start_addr = {20'h00000, dh_r[3:0], tf_cur_r[5], tf_cur_r[4],
                    tf_cur_r[3]};
    end
  end

  // Extended errors name the failing sector, otherwise the last one done.
  assign end_addr = (ext_r & err_flag_r) ? cur_r : last_r;

  // Ready and seek-complete always read one: this logic has no spin-up.
  assign status = {(state_r != ST_IDLE) & ~drq_r, 1'b1, 1'b0, 1'b1,
                   drq_r, 1'b0, 1'b0, err_flag_r};

  // ----------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      state_r <= ST_IDLE;
      drq_r <= 1'b0;
      ext_r <= 1'b0;
      lba_r <= 1'b0;
      rem_in_r <= '0;
      blk_left_r <= 8'h00;
      in_word_r <= 8'h00;
      err_r <= ERR_RESET;
      err_flag_r <= 1'b0;
    end
    else if (I_CE)
    begin
      unique case (state_r)
        ST_IDLE:
          if (cmd_wr)
          begin
            err_r <= ERR_RESET;
            err_flag_r <= ~cmd_ok;
            err_r[ERR_ABT_BIT] <= ~cmd_ok;
            if (cmd_ok)
            begin
              ext_r <= is_ext;
              lba_r <= is_ext | dh_r[DH_LBA_BIT];
              rem_in_r <= count_req;
              blk_left_r <= blk_len(count_req, I_BLOCK_SIZE);
              in_word_r <= 8'h00;
              drq_r <= 1'b1;
              state_r <= ST_XFER;
            end
          end
        ST_XFER:
          if (fail)
          begin
            err_r[ERR_IDN_BIT] <= 1'b1;
            err_flag_r <= 1'b1;
            drq_r <= 1'b0;
            state_r <= ST_END;
          end
          else if (data_acc)
          begin
            in_word_r <= in_word_r + 8'h01;
            if (sector_in)
            begin
              rem_in_r <= rem_in_r - 17'h00001;
              blk_left_r <= blk_left_r - 8'h01;
              if (blk_left_r == 8'h01)
              begin
                drq_r <= 1'b0;
                state_r <= ST_COMMIT;
              end
            end
          end
        ST_COMMIT:
          if (fail)
          begin
            err_r[ERR_IDN_BIT] <= 1'b1;
            err_flag_r <= 1'b1;
            state_r <= ST_END;
          end
          else if (rem_r == rem_in_r)
          begin
            if (rem_in_r == '0)
              state_r <= ST_END;
            else
            begin
              blk_left_r <= blk_len(rem_in_r, I_BLOCK_SIZE);
              drq_r <= 1'b1;
              state_r <= ST_XFER;
            end
          end
        ST_END:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt: one per block handed out after the first, at the end, and on an aborted command
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_INTRQ <= 1'b0;
    else if (I_CE)
    begin
      if (host_rd && I_HOST_REQ.addr == TF_CMD_STAT)
        O_INTRQ <= 1'b0;
      // Placed after the clear so a new event in the same cycle wins.
      if ((state_r == ST_COMMIT && !fail && rem_r == rem_in_r
           && rem_in_r != '0) || state_r == ST_END
          || (cmd_wr && !cmd_ok))
        O_INTRQ <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Media progress: remaining count and address tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      rem_r <= '0;
      out_word_r <= 8'h00;
      cur_r <= '0;
      last_r <= '0;
    end
    else if (I_CE)
    begin
      if (cmd_wr && cmd_ok)
      begin
        rem_r <= count_req;
        out_word_r <= 8'h00;
        cur_r <= start_addr;
        last_r <= start_addr;
      end
      else if (fail)
        out_word_r <= 8'h00;
      else if (O_MEDIA_VALID && I_MEDIA_READY)
      begin
        out_word_r <= out_word_r + 8'h01;
        if (sector_commit)
        begin
          rem_r <= rem_r - 17'h00001;
          last_r <= cur_r;
          cur_r <= next_addr(cur_r, lba_r);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Task-file registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      for (int i = 2; i <= 5; i++)
      begin
        tf_cur_r[i] <= (i == 2 || i == 3) ? TF_RESET_ONE : TF_RESET_BYTE;
        tf_prev_r[i] <= TF_RESET_BYTE;
      end
      dh_r <= TF_RESET_BYTE;
    end
    else if (I_CE)
    begin
      if (state_r == ST_END)
      begin
        tf_cur_r[2] <= rem_r[7:0];
        tf_prev_r[2] <= rem_r[15:8];
        tf_cur_r[3] <= end_addr[7:0];
        tf_cur_r[4] <= end_addr[15:8];
        tf_cur_r[5] <= end_addr[23:16];
        tf_prev_r[3] <= end_addr[31:24];
        tf_prev_r[4] <= end_addr[39:32];
        tf_prev_r[5] <= end_addr[47:40];
        if (!ext_r)
          dh_r[3:0] <= end_addr[27:24];
      end
      else if (host_wr && state_r == ST_IDLE)
      begin
        // Each write to the count, sector or cylinder registers pushes the older byte into the previous slot.
        if (I_HOST_REQ.addr >= TF_COUNT && I_HOST_REQ.addr <= TF_CYL_HI)
        begin
          tf_prev_r[I_HOST_REQ.addr] <= tf_cur_r[I_HOST_REQ.addr];
          tf_cur_r[I_HOST_REQ.addr] <= I_HOST_REQ.wdata[7:0];
        end
        if (I_HOST_REQ.addr == TF_DEV_HEAD)
          dh_r <= I_HOST_REQ.wdata[7:0];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_RDATA <= 16'h0000;
    else if (host_rd)
    begin
      unique case (I_HOST_REQ.addr)
        TF_DATA: O_RDATA <= 16'h0000;
        TF_FEAT_ERR: O_RDATA <= {8'h00, err_r};
        TF_DEV_HEAD: O_RDATA <= {8'h00, dh_r};
        TF_CMD_STAT: O_RDATA <= {8'h00, status};
        default: O_RDATA <= {8'h00, I_HOB ? tf_prev_r[I_HOST_REQ.addr]
                                          : tf_cur_r[I_HOST_REQ.addr]};
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Data buffer toward the media
  // ----------------------------------------------------------------------
  mswc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_ce(I_CE),
    .i_flush(fail),
    .i_valid(data_acc),
    .i_data(I_HOST_REQ.wdata),
    .o_ready(fifo_ready),
    .o_valid(O_MEDIA_VALID),
    .o_data(O_MEDIA_DATA),
    .i_ready(I_MEDIA_READY)
  );
  assign O_DATA_READY = fifo_ready;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_c5_decode: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cmd_wr && I_HOST_REQ.wdata[7:0] == 8'hC5 && I_BLOCK_SIZE != 8'h00
    |=> state_r == ST_XFER && drq_r && !ext_r)
    else $error("write multiple not started");
  a_ext_decode: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cmd_wr && I_HOST_REQ.wdata[7:0] == 8'h39 && I_BLOCK_SIZE != 8'h00
    |=> state_r == ST_XFER && ext_r && lba_r)
    else $error("extended write not started");
  a_count_zero28: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cmd_wr && cmd_ok && !is_ext && tf_cur_r[2] == 8'h00
    |=> rem_r == 17'h00100)
    else $error("zero 28-bit count not 256");
  a_count_ext: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cmd_wr && cmd_ok && is_ext
    |=> rem_r == (($past(tf_prev_r[2]) == 8'h00 && $past(tf_cur_r[2])
        == 8'h00) ? 17'h10000 : {1'b0, $past(tf_prev_r[2]),
        $past(tf_cur_r[2])}))
    else $error("extended count wrong");
  a_lba28_form: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    cmd_wr && cmd_ok && !is_ext
    |=> cur_r == {20'h00000, $past(dh_r[3:0]), $past(tf_cur_r[5]),
        $past(tf_cur_r[4]), $past(tf_cur_r[3])})
    else $error("28-bit start address wrong");
  a_drq_per_block: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    I_CE && sector_in && !fail && blk_left_r == 8'h01
    |=> !drq_r && state_r == ST_COMMIT)
    else $error("block did not end");
  a_irq_cause: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $rose(O_INTRQ) |-> $past(state_r) == ST_END
    || ($past(state_r) == ST_COMMIT && state_r == ST_XFER)
    || $past(cmd_wr))
    else $error("interrupt without block or end");
  a_err_bits: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    err_r[7:5] == 3'b000 && err_r[3] == 1'b0 && err_r[1:0] == 2'b00
    && (err_r != 8'h00 || !err_flag_r))
    else $error("illegal error bits");
  a_end_status: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    I_CE && state_r == ST_END |=> !status[ST_BSY_BIT] && !status[ST_DF_BIT]
    && !status[ST_DRQ_BIT])
    else $error("end status busy or fault");
  a_end_count: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    I_CE && state_r == ST_END |=> tf_cur_r[2] == $past(rem_r[7:0])
    && (err_flag_r || rem_r == 17'h00000))
    else $error("remaining count wrong");
endmodule

// file: mswc_media_model.sv
// Media-side partner: takes the write stream and checks word order.
`timescale 1ns/100ps
module mswc_media_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Bench control
  input wire logic i_clear,
  input wire logic i_slow,
  // Write stream
  input wire logic i_valid,
  input wire logic [15:0] i_data,
  output logic o_ready,
  // Tallies
  output logic [31:0] o_taken,
  output logic [31:0] o_bad
);
  logic [2:0] phase_r;

  // A slow medium takes two words in eight cycles, slower than the host,
  // so the buffer fills and must refuse.
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      phase_r <= 3'h0;
      o_ready <= 1'b0;
    end
    else
    begin
      phase_r <= phase_r + 3'h1;
      o_ready <= !i_slow || (phase_r < 3'h2);
    end

  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
    begin
      o_taken <= 32'h0;
      o_bad <= 32'h0;
    end
    else if (i_clear)
      o_taken <= 32'h0;
    else if (i_valid && o_ready)
    begin
      o_taken <= o_taken + 32'h1;
      if (i_data !== (o_taken[15:0] ^ 16'hA5C3))
        o_bad <= o_bad + 32'h1;
    end
endmodule

// file: mswc_write_multi_test.sv
// Self-checking bench for the block-mode sector write command logic.
`timescale 1ns/100ps
`define CHK(g, e) \
  begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module mswc_write_multi_test;
  import mswc_pkg::*;
  logic clk, dready, intrq, mvalid, mready;
  logic arst_n = 1'b0, ce = 1'b1, hob = 1'b0, mfail = 1'b0;
  logic mclear = 1'b0, mslow = 1'b0, saw_full = 1'b0;
  mswc_host_req_t req = '0;
  logic [7:0] bsize = 8'h00;
  logic [15:0] rdata, mdata, rd_v, wn;
  logic [31:0] mtaken, mbad;
  int errors = 0;
  int tests_run = 0;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  mswc_write_multi dut (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_HOST_REQ(req),
    .I_HOB(hob), .I_BLOCK_SIZE(bsize), .O_RDATA(rdata),
    .O_DATA_READY(dready), .O_INTRQ(intrq), .O_MEDIA_VALID(mvalid),
    .O_MEDIA_DATA(mdata), .I_MEDIA_READY(mready), .I_MEDIA_FAIL(mfail)
  );

  mswc_media_model media (
    .i_clk(clk), .i_arst_n(arst_n), .i_clear(mclear), .i_slow(mslow),
    .i_valid(mvalid), .i_data(mdata), .o_ready(mready),
    .o_taken(mtaken), .o_bad(mbad)
  );

  always @(posedge clk)
    if (dready === 1'b0)
      saw_full <= 1'b1;

  // ----------------------------------------------------------------------
  // Host cycles
  // ----------------------------------------------------------------------
  task automatic tf_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data is registered and holds, so it is taken one edge later.
  task automatic tf_rd(input logic [2:0] a, input logic h);
    @(posedge clk);
    hob <= h;
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    rd_v = rdata;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    tf_rd(a, 1'b0);
    `CHK(rd_v, {8'h00, e})
  endtask

  task automatic chk_tf(input logic h, input logic [7:0] e [4]);
    for (int i = 0; i < 4; i++)
    begin
      tf_rd(3'(TF_COUNT + i), h);
      `CHK(rd_v, {8'h00, e[i]})
    end
  endtask

  // The block size must stand before the command, which reads it for the first block.
  task automatic ld(input logic [7:0] v [5], input logic [7:0] bs);
    fresh(bs);
    for (int i = 0; i < 5; i++)
      tf_wr(3'(TF_COUNT + i), {8'h00, v[i]});
    tf_wr(TF_CMD_STAT, 16'h00C5);
  endtask

  task automatic fresh(input logic [7:0] bs);
    @(posedge clk);
    mclear <= 1'b1;
    wn = 16'h0000;
    @(posedge clk);
    mclear <= 1'b0;
    mslow <= 1'b0;
    bsize <= bs;
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 4000 && intrq !== 1'b1; n++)
      @(posedge clk);
    `CHK(intrq, 1'b1)
  endtask

  // Each word waits for room; a write while full would be lost.
  task automatic send(input int nw);
    for (int i = 0; i < nw; i++)
    begin
      @(posedge clk);
      for (int k = 0; k < 50 && dready !== 1'b1; k++)
        @(posedge clk);
      req <= '{addr: TF_DATA, wr: 1'b1, rd: 1'b0, wdata: wn ^ 16'hA5C3};
      wn++;
      @(posedge clk);
      req.wr <= 1'b0;
      if (i % 256 == 128)
        `CHK(intrq, 1'b0)
    end
  endtask

  task automatic fail();
    @(posedge clk);
    mfail <= 1'b1;
    @(posedge clk);
    mfail <= 1'b0;
    wait_irq();
    rd_chk(TF_CMD_STAT, 8'h51);
    rd_chk(TF_FEAT_ERR, 8'h10);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_abort();
    bsize <= 8'h04;
    tf_wr(TF_CMD_STAT, 16'h00EF);
    wait_irq();
    rd_chk(TF_FEAT_ERR, 8'h04);
    rd_chk(TF_CMD_STAT, 8'h51);
    `CHK(intrq, 1'b0)
    bsize <= 8'h00;
    tf_wr(TF_CMD_STAT, 16'h00C5);
    wait_irq();
    rd_chk(TF_CMD_STAT, 8'h51);
    rd_chk(TF_COUNT, 8'h01);
    $display("test abort done");
  endtask

  task automatic t_lba();
    ld('{8'h03, 8'h56, 8'h34, 8'h12, 8'hEA}, 8'h02);
    mslow <= 1'b1;
    rd_chk(TF_CMD_STAT, 8'h58);
    send(512);
    wait_irq();
    rd_chk(TF_CMD_STAT, 8'h58);
    send(256);
    wait_irq();
    rd_chk(TF_CMD_STAT, 8'h50);
    chk_tf(1'b0, '{8'h00, 8'h58, 8'h34, 8'h12});
    tf_rd(TF_DEV_HEAD, 1'b0);
    `CHK(rd_v[3:0], 4'hA)
    `CHK(mtaken, 32'h300)
    `CHK(saw_full, 1'b1)
    $display("test lba28 done");
  endtask

  task automatic t_chs();
    ld('{8'h00, 8'h3F, 8'h05, 8'h01, 8'hA2}, 8'h04);
    send(522);
    fail();
    chk_tf(1'b0, '{8'hFE, 8'h01, 8'h05, 8'h01});
    tf_rd(TF_DEV_HEAD, 1'b0);
    `CHK(rd_v[3:0], 4'h3)
    $display("test chs done");
  endtask

  task automatic t_ext(input logic [7:0] cp, cc, input logic [15:0] rem);
    logic [7:0] v [8];
    v = '{cp, cc, 8'h44, 8'hFF, 8'h55, 8'h22, 8'h66, 8'h33};
    fresh(8'h04);
    for (int i = 0; i < 8; i++)
      tf_wr(3'(TF_COUNT + i / 2), {8'h00, v[i]});
    tf_wr(TF_DEV_HEAD, 16'h0040);
    tf_wr(TF_CMD_STAT, 16'h0039);
    send(261);
    fail();
    chk_tf(1'b0, '{rem[7:0], 8'h00, 8'h23, 8'h33});
    chk_tf(1'b1, '{rem[15:8], 8'h44, 8'h55, 8'h66});
    $display("test ext done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    `CHK(intrq, 1'b0)
    `CHK(dready, 1'b1)
    rd_chk(TF_CMD_STAT, 8'h50);
    rd_chk(TF_COUNT, 8'h01);
    $display("test reset done");
    t_abort();
    t_lba();
    t_chs();
    t_ext(8'h01, 8'h05, 16'h0104);
    t_ext(8'h00, 8'h00, 16'hFFFF);
    `CHK(mbad, 32'h0)
    end_of_test();
  end

  initial
  begin
    #300000;
    errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
